// >>> taf_pkg.sv
package taf_pkg;

  // Log image geometry
  localparam int LOG_BYTES     = 147;
  localparam int HDR_BYTES     = 27;
  localparam int REC_BYTES     = 20;
  localparam int VOL_RECS      = 6;
  localparam int NV_RECS       = 4;
  localparam int NV_BYTES      = HDR_BYTES + NV_RECS * REC_BYTES;
  localparam int PREFACE_BYTES = 4;
  localparam int HDR_BITS      = HDR_BYTES * 8;
  localparam int REC_BITS      = REC_BYTES * 8;

  // Header field byte offsets
  localparam int OFS_PREFACE = 0;
  localparam int OFS_SOURCE  = 4;
  localparam int OFS_STAMP   = 5;
  localparam int OFS_PEAKS   = 11;
  localparam int OFS_TEMPS   = 21;
  localparam int OFS_RECORDS = 27;

  // Fault source codes
  localparam logic [7:0] SRC_CH0_BASE = 8'h00;
  localparam logic [7:0] SRC_CH1_BASE = 8'h10;
  localparam logic [7:0] SRC_MANUAL   = 8'hFF;

  // Nonvolatile copy temperature window, degrees C
  localparam logic signed [9:0] TEMP_HOT_C  = 10'sh082;
  localparam logic signed [9:0] TEMP_COOL_C = 10'sh07D;

  // Reset values and block count answers
  localparam logic [7:0]  BYTE_RST  = 8'h00;
  localparam logic [15:0] PEAK_RST  = 16'h0000;
  localparam logic [7:0]  COUNT_NONE = 8'h00;
  localparam logic [7:0]  COUNT_FULL = 8'h93;

  // One monitor event record, first field in the high bits
  typedef struct packed {
    logic [15:0] vout0;
    logic [15:0] vout1;
    logic [15:0] iout0;
    logic [15:0] iout1;
    logic [15:0] vin;
    logic [15:0] spare;
    logic [7:0]  vstat0;
    logic [7:0]  vstat1;
    logic [15:0] word0;
    logic [15:0] word1;
    logic [7:0]  vsb0;
    logic [7:0]  vsb1;
  } taf_rec_t;

  typedef enum logic [2:0] {
    ST_BOOT  = 3'b000,
    ST_LIVE  = 3'b001,
    ST_WAIT  = 3'b011,
    ST_BUILD = 3'b010,
    ST_COPY  = 3'b110,
    ST_DONE  = 3'b111
  } taf_state_t;

  typedef enum logic [2:0] {
    CMD_COUNT = 3'b000,
    CMD_BYTE  = 3'b001,
    CMD_CLEAR = 3'b010,
    CMD_ERASE = 3'b011,
    CMD_STORE = 3'b100
  } taf_cmd_t;

  typedef struct packed {
    taf_cmd_t   op;
    logic [7:0] idx;
  } taf_lreq_t;

endpackage

// >>> taf_sync.sv
`timescale 1ns/1ps
module taf_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,    // Destination clock
  input  wire logic         arst_n, // Async reset
  input  wire logic [W-1:0] d,      // Foreign input
  output logic      [W-1:0] q       // Agreed value
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  initial
  begin
    if (W < 1) $error("taf_sync: W must be positive");
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_r <= RST;
      s2_r <= RST;
      s3_r <= RST;
      q    <= RST;
    end
    else
    begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        q <= s3_r;
    end
  end
endmodule

// >>> taf_peak.sv
`timescale 1ns/1ps
module taf_peak (
  input  wire logic        clk,    // System clock
  input  wire logic        arst_n, // Async reset
  input  wire logic        clr,    // Peak clear
  input  wire logic        vld,    // New sample
  input  wire logic [15:0] val,    // Sample
  output logic      [15:0] peak    // Held maximum
);
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      peak <= taf_pkg::PEAK_RST;
    else if (clr)
      peak <= taf_pkg::PEAK_RST;
    else if (vld && val > peak)
      peak <= val;
  end
endmodule

// >>> taf_fault_log.sv
`timescale 1ns/1ps
// Contract
// - Before any logged fault, every new monitor record refreshes the history.
// - PWM fault shutdown freezes history, exposes it for reading, copies to NVM.
// - NVM copy waits while die above 130C, resumes below 125C.
// - Faults entering on the fault pins never create a log.
// - Power-up scans NVM for a stored log and sets the valid flag.
// - A found stored log blocks new logging until clear-faults.
// - Partial stored log also needs erase after clear before logging resumes.
// - Log block read is 147 bytes long when a log is present.
// - With no log present the block count reads zero.
// - Each record is one full ADC pass plus its status.
// - Six newest records kept in RAM newest first, four in NVM.
// - Finish current ADC pass; note converting input at fault time.
// - Header bytes 0-26, fault record 27-46, five older records to 146.
// - Bytes 0-3 carry a four-character preface when a log exists.
// - Bytes 5-10 carry the 48-bit timestamp, low byte first.
// - Bytes 11-20 carry peak voltages and currents, high byte first.
// - Bytes 21-26 carry three last-event temperatures, high byte first.
// - Byte 4 source: channel 0 codes, channel 1 plus 0x10, manual 0xFF.
// - Record layout: volts, currents, input, spare, status bytes and words.
module taf_fault_log #(
  parameter logic [31:0] PREFACE = 32'h4142_4344 // Arbitrary identity value
) (
  input  wire logic                mclk,         // System clock
  input  wire logic                arst_n,       // Async reset
  input  wire logic                lnk_clk,      // Host link clock
  input  wire logic                mon_valid,    // ADC pass completed
  input  wire taf_pkg::taf_rec_t   mon_rec,      // Completed pass record
  input  wire logic [3:0]          mon_input,    // Input now converting
  input  wire logic [15:0]         ext_temp0,    // External sensor 0
  input  wire logic [15:0]         ext_temp1,    // External sensor 1
  input  wire logic [15:0]         int_temp,     // Internal sensor
  input  wire logic signed [9:0]   die_temp_c,   // Die temperature
  input  wire logic [47:0]         timestamp,    // Shared-clock count
  input  wire logic                clear_peaks,  // Peak clear
  input  wire logic [1:0]          fault_off,    // Channel fault shutdown
  input  wire logic [3:0]          cause0,       // Channel 0 cause
  input  wire logic [3:0]          cause1,       // Channel 1 cause
  input  wire logic [1:0]          fault_pin_n,  // External fault pins
  input  wire logic                mem_fault,    // Memory fault status
  input  wire logic                lk_req_valid, // Host request strobe
  input  wire taf_pkg::taf_lreq_t  lk_req,       // Host request
  output logic                     lk_busy,      // Request in flight
  output logic                     lk_rsp_valid, // Answer strobe
  output logic [7:0]               lk_rsp_data,  // Answer byte
  output logic                     nv_wr_req,    // NVM write request
  output logic [7:0]               nv_wr_addr,   // NVM write address
  output logic [7:0]               nv_wr_data,   // NVM write data
  input  wire logic                nv_wr_ack,    // NVM write done
  output logic                     nv_rd_req,    // NVM read request
  output logic [7:0]               nv_rd_addr,   // NVM read address
  input  wire logic [7:0]          nv_rd_data,   // NVM read data
  input  wire logic                nv_rd_valid,  // NVM read done
  output logic                     nv_erase,     // NVM log erase pulse
  output logic                     valid_log,    // Vendor status bit
  output logic                     log_present,  // Image readable
  output logic                     logging_en,   // Logging armed
  output logic                     need_erase,   // Erase still owed
  output logic                     copy_hot,     // NVM copy held off
  output logic [3:0]               fault_input,  // Input at fault
  output logic                     ext_fault     // Fault pin active
);
  localparam int IW = 8;

  taf_pkg::taf_state_t state_r;
  taf_pkg::taf_rec_t   hist_r [taf_pkg::VOL_RECS];
  logic [7:0]          img_r  [taf_pkg::LOG_BYTES];
  logic [2:0]          wr_ptr_r;
  logic [IW-1:0]       idx_r;
  logic [7:0]          src_r;
  logic [47:0]         stamp_r;
  logic [15:0]         t0_r, t1_r, ti_r;
  logic                block_r;
  logic                fault_d_r;
  logic [7:0]          bld_byte;
  logic [taf_pkg::HDR_BITS-1:0] hdr;
  logic [15:0]         pk_vout0, pk_vout1, pk_iout0, pk_iout1, pk_vin;
  logic [1:0]          pins_q;
  logic                hist_wr;
  logic                trig;
  logic                fault_rise;

  // Link domain
  taf_pkg::taf_lreq_t  lk_hold_r;
  logic                lk_tgl_r;
  logic                lk_ack_seen_r;
  logic                ack_tgl_l;
  // System domain side of the handshake
  logic                req_tgl_m;
  logic                req_seen_r;
  logic                ack_tgl_r;
  logic [7:0]          m_rsp_r;
  logic                req_pend;
  logic                cmd_clear, cmd_erase, cmd_store;

  taf_sync #(.W(1), .RST(1'b0)) u_req_sync (
    .clk    (mclk),
    .arst_n (arst_n),
    .d      (lk_tgl_r),
    .q      (req_tgl_m)
  );

  taf_sync #(.W(1), .RST(1'b0)) u_ack_sync (
    .clk    (lnk_clk),
    .arst_n (arst_n),
    .d      (ack_tgl_r),
    .q      (ack_tgl_l)
  );

  taf_sync #(.W(2), .RST(2'b11)) u_pin_sync (
    .clk    (mclk),
    .arst_n (arst_n),
    .d      (fault_pin_n),
    .q      (pins_q)
  );

  // Pins are only reported, never fed into the trigger
  assign ext_fault = ~&pins_q;

  taf_peak u_pk_vout0 (.clk(mclk), .arst_n(arst_n), .clr(clear_peaks),
    .vld(mon_valid), .val(mon_rec.vout0), .peak(pk_vout0));
  taf_peak u_pk_vout1 (.clk(mclk), .arst_n(arst_n), .clr(clear_peaks),
    .vld(mon_valid), .val(mon_rec.vout1), .peak(pk_vout1));
  taf_peak u_pk_iout0 (.clk(mclk), .arst_n(arst_n), .clr(clear_peaks),
    .vld(mon_valid), .val(mon_rec.iout0), .peak(pk_iout0));
  taf_peak u_pk_iout1 (.clk(mclk), .arst_n(arst_n), .clr(clear_peaks),
    .vld(mon_valid), .val(mon_rec.iout1), .peak(pk_iout1));
  taf_peak u_pk_vin (.clk(mclk), .arst_n(arst_n), .clr(clear_peaks),
    .vld(mon_valid), .val(mon_rec.vin), .peak(pk_vin));

  // Link side: hold request, flip toggle, wait for acknowledge
  always_ff @(posedge lnk_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lk_hold_r     <= '0;
      lk_tgl_r      <= 1'b0;
      lk_ack_seen_r <= 1'b0;
      lk_busy       <= 1'b0;
      lk_rsp_valid  <= 1'b0;
      lk_rsp_data   <= taf_pkg::BYTE_RST;
    end
    else
    begin
      lk_rsp_valid <= 1'b0;
      if (lk_req_valid && !lk_busy)
      begin
        lk_hold_r <= lk_req;
        lk_tgl_r  <= ~lk_tgl_r;
        lk_busy   <= 1'b1;
      end
      else if (lk_busy && (ack_tgl_l != lk_ack_seen_r))
      begin
        // Answer word stays still until the next request is answered
        lk_ack_seen_r <= ack_tgl_l;
        lk_busy       <= 1'b0;
        lk_rsp_valid  <= 1'b1;
        lk_rsp_data   <= m_rsp_r;
      end
    end
  end

  assign req_pend  = req_tgl_m != req_seen_r;
  assign cmd_clear = req_pend && lk_hold_r.op == taf_pkg::CMD_CLEAR;
  assign cmd_erase = req_pend && lk_hold_r.op == taf_pkg::CMD_ERASE;
  assign cmd_store = req_pend && lk_hold_r.op == taf_pkg::CMD_STORE;

  // Requests served in one system cycle
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      req_seen_r <= 1'b0;
      ack_tgl_r  <= 1'b0;
      m_rsp_r    <= taf_pkg::BYTE_RST;
    end
    else if (req_pend)
    begin
      req_seen_r <= req_tgl_m;
      ack_tgl_r  <= ~ack_tgl_r;
      m_rsp_r    <= taf_pkg::BYTE_RST;
      if (lk_hold_r.op == taf_pkg::CMD_COUNT)
        m_rsp_r <= log_present ? taf_pkg::COUNT_FULL
                               : taf_pkg::COUNT_NONE;
      else if (lk_hold_r.op == taf_pkg::CMD_BYTE && log_present &&
               int'(lk_hold_r.idx) < taf_pkg::LOG_BYTES)
        m_rsp_r <= img_r[lk_hold_r.idx];
    end
  end

  // Die temperature hysteresis for the NVM copy
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      copy_hot <= 1'b0;
    else if (die_temp_c > taf_pkg::TEMP_HOT_C)
      copy_hot <= 1'b1;
    else if (die_temp_c < taf_pkg::TEMP_COOL_C)
      copy_hot <= 1'b0;
  end

  assign fault_rise = |(fault_off & ~{fault_d_r, fault_d_r}) ||
                      (fault_off != 2'b00 && !fault_d_r);
  assign trig       = fault_rise || cmd_store;
  assign hist_wr    = mon_valid &&
                      (state_r == taf_pkg::ST_LIVE ||
                       state_r == taf_pkg::ST_WAIT);
  assign logging_en = !block_r && !need_erase;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      fault_d_r <= 1'b0;
    else
      fault_d_r <= |fault_off;
  end

  // Circular history of completed passes
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < taf_pkg::VOL_RECS; i++)
        hist_r[i] <= '0;
      wr_ptr_r <= 3'h0;
      t0_r     <= taf_pkg::PEAK_RST;
      t1_r     <= taf_pkg::PEAK_RST;
      ti_r     <= taf_pkg::PEAK_RST;
    end
    else if (hist_wr)
    begin
      hist_r[wr_ptr_r] <= mon_rec;
      wr_ptr_r <= (int'(wr_ptr_r) == taf_pkg::VOL_RECS - 1) ?
                  3'h0 : wr_ptr_r + 3'h1;
      t0_r     <= ext_temp0;
      t1_r     <= ext_temp1;
      ti_r     <= int_temp;
    end
  end

  // Header image, stamp reversed so its low byte leads
  assign hdr = {PREFACE, src_r,
                stamp_r[7:0], stamp_r[15:8], stamp_r[23:16],
                stamp_r[31:24], stamp_r[39:32], stamp_r[47:40],
                pk_vout0, pk_vout1, pk_iout0, pk_iout1, pk_vin,
                t0_r, t1_r, ti_r};

  always_comb
  begin
    int bi;
    int k;
    int j;
    int slot;
    taf_pkg::taf_rec_t rec;
    bi   = int'(idx_r);
    k    = 0;
    j    = 0;
    slot = 0;
    rec  = '0;
    if (bi < taf_pkg::OFS_RECORDS)
      bld_byte = hdr[taf_pkg::HDR_BITS - 1 - 8 * bi -: 8];
    else
    begin
      k    = (bi - taf_pkg::OFS_RECORDS) / taf_pkg::REC_BYTES;
      j    = (bi - taf_pkg::OFS_RECORDS) % taf_pkg::REC_BYTES;
      slot = (int'(wr_ptr_r) + 2 * taf_pkg::VOL_RECS - 1 - k) %
             taf_pkg::VOL_RECS;
      rec  = hist_r[slot];
      bld_byte = rec[taf_pkg::REC_BITS - 1 - 8 * j -: 8];
    end
  end

  assign nv_wr_req  = state_r == taf_pkg::ST_COPY && !copy_hot;
  assign nv_wr_addr = idx_r;
  assign nv_wr_data = img_r[idx_r];
  assign nv_rd_req  = state_r == taf_pkg::ST_BOOT;
  assign nv_rd_addr = idx_r;

  // Log sequencer
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_r     <= taf_pkg::ST_BOOT;
      idx_r       <= '0;
      src_r       <= taf_pkg::BYTE_RST;
      stamp_r     <= '0;
      fault_input <= 4'h0;
      block_r     <= 1'b0;
      need_erase  <= 1'b0;
      valid_log   <= 1'b0;
      log_present <= 1'b0;
      nv_erase    <= 1'b0;
      for (int i = 0; i < taf_pkg::LOG_BYTES; i++)
        img_r[i] <= taf_pkg::BYTE_RST;
    end
    else
    begin
      nv_erase <= 1'b0;
      if (cmd_clear)
        block_r <= 1'b0;
      if (cmd_erase && !block_r)
      begin
        // Erase before clear leaves the owed erase pending
        need_erase  <= 1'b0;
        valid_log   <= 1'b0;
        log_present <= 1'b0;
        nv_erase    <= 1'b1;
      end
      unique case (state_r)
        taf_pkg::ST_BOOT:
        begin
          if (nv_rd_valid)
          begin
            img_r[idx_r] <= nv_rd_data;
            idx_r        <= idx_r + 8'h01;
            if (int'(idx_r) == taf_pkg::NV_BYTES - 1)
            begin
              idx_r <= '0;
              state_r <= taf_pkg::ST_LIVE;
              if ({img_r[0], img_r[1], img_r[2], img_r[3]} == PREFACE)
              begin
                valid_log   <= 1'b1;
                log_present <= 1'b1;
                block_r     <= 1'b1;
                need_erase  <= mem_fault;
              end
            end
          end
        end
        taf_pkg::ST_LIVE:
        begin
          if (trig && logging_en)
          begin
            src_r <= cmd_store ? taf_pkg::SRC_MANUAL :
                     fault_off[0] ? (taf_pkg::SRC_CH0_BASE | {4'h0, cause0}) :
                     (taf_pkg::SRC_CH1_BASE | {4'h0, cause1});
            stamp_r     <= timestamp;
            fault_input <= mon_input;
            state_r     <= taf_pkg::ST_WAIT;
          end
        end
        taf_pkg::ST_WAIT:
        begin
          if (mon_valid)
          begin
            idx_r   <= '0;
            state_r <= taf_pkg::ST_BUILD;
          end
        end
        taf_pkg::ST_BUILD:
        begin
          img_r[idx_r] <= bld_byte;
          idx_r        <= idx_r + 8'h01;
          if (int'(idx_r) == taf_pkg::LOG_BYTES - 1)
          begin
            idx_r       <= '0;
            log_present <= 1'b1;
            state_r     <= taf_pkg::ST_COPY;
          end
        end
        taf_pkg::ST_COPY:
        begin
          if (nv_wr_req && nv_wr_ack)
          begin
            idx_r <= idx_r + 8'h01;
            if (int'(idx_r) == taf_pkg::NV_BYTES - 1)
            begin
              idx_r     <= '0;
              valid_log <= 1'b1;
              block_r   <= 1'b1;
              state_r   <= taf_pkg::ST_DONE;
            end
          end
        end
        taf_pkg::ST_DONE:
        begin
          if (logging_en)
            state_r <= taf_pkg::ST_LIVE;
        end
        default:
          state_r <= taf_pkg::ST_BOOT;
      endcase
    end
  end

endmodule

// >>> taf_fault_log_properties.sv
`timescale 1ns/1ps
module taf_fault_log_props (
  input wire logic              mclk,         // Clock
  input wire logic              arst_n,       // Reset
  input wire logic              lnk_clk,      // Link clock
  input wire logic              lk_req_valid, // Request
  input wire logic              lk_busy,      // Busy
  input wire logic              lk_rsp_valid, // Answer
  input wire logic              nv_wr_req,    // Write req
  input wire logic [7:0]        nv_wr_addr,   // Write addr
  input wire logic [7:0]        nv_wr_data,   // Write data
  input wire logic              nv_wr_ack,    // Write ack
  input wire logic              nv_rd_req,    // Read req
  input wire logic              nv_erase,     // Erase
  input wire logic              copy_hot,     // Copy held
  input wire logic signed [9:0] die_temp_c    // Die temp
);
  a_take_busy: assert property (@(posedge lnk_clk) disable iff (!arst_n)
    lk_req_valid && !lk_busy |=> lk_busy) else $error("no busy on take");
  a_answer_time: assert property (@(posedge lnk_clk) disable iff (!arst_n)
    lk_req_valid && !lk_busy |-> ##[2:20] lk_rsp_valid)
    else $error("answer late");
  a_rsp_frees: assert property (@(posedge lnk_clk) disable iff (!arst_n)
    $fell(lk_busy) |-> lk_rsp_valid) else $error("busy fell alone");
  a_wr_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    nv_wr_req && !nv_wr_ack |=> $stable(nv_wr_addr) && $stable(nv_wr_data))
    else $error("write moved early");
  a_wr_step: assert property (@(posedge mclk) disable iff (!arst_n)
    nv_wr_req && nv_wr_ack |=>
    !nv_wr_req || nv_wr_addr == 8'($past(nv_wr_addr) + 8'h01))
    else $error("write address skipped");
  a_hot_quiet: assert property (@(posedge mclk) disable iff (!arst_n)
    copy_hot |-> !nv_wr_req) else $error("write while hot");
  a_hot_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    copy_hot && die_temp_c >= taf_pkg::TEMP_COOL_C |=> copy_hot)
    else $error("hot hold dropped");
  a_cool_stay: assert property (@(posedge mclk) disable iff (!arst_n)
    !copy_hot && die_temp_c <= taf_pkg::TEMP_HOT_C |=> !copy_hot)
    else $error("hot hold without heat");
  a_erase_pulse: assert property (@(posedge mclk) disable iff (!arst_n)
    nv_erase |=> !nv_erase) else $error("erase too long");
  a_boot_excl: assert property (@(posedge mclk) disable iff (!arst_n)
    nv_rd_req |-> !nv_wr_req) else $error("write during boot");
  c_take: cover property (@(posedge lnk_clk) lk_req_valid && !lk_busy);
  c_hot: cover property (@(posedge mclk) copy_hot);
  c_erase: cover property (@(posedge mclk) nv_erase);
endmodule

bind taf_fault_log taf_fault_log_props i_props (
  .mclk, .arst_n, .lnk_clk, .lk_req_valid, .lk_busy, .lk_rsp_valid,
  .nv_wr_req, .nv_wr_addr, .nv_wr_data, .nv_wr_ack, .nv_rd_req, .nv_erase,
  .copy_hot, .die_temp_c
);

// >>> taf_host_model.sv
`timescale 1ns/1ps
module taf_host_model (
  input  wire logic        lnk_clk,      // Link clock
  input  wire logic        lk_busy,      // Busy
  input  wire logic        lk_rsp_valid, // Answer
  input  wire logic [7:0]  lk_rsp_data,  // Answer byte
  output logic             lk_req_valid, // Request
  output taf_pkg::taf_lreq_t lk_req      // Request word
);
  initial
  begin
    {lk_req_valid, lk_req} = '0;
  end
  // Held until taken, then wait a bounded time for the answer
  task automatic xfer(input taf_pkg::taf_cmd_t op, input logic [7:0] idx,
                      output logic [7:0] d, output bit ok);
    int n;
    @(posedge lnk_clk);
    lk_req_valid <= 1'b1;
    lk_req <= '{op: op, idx: idx};
    do @(posedge lnk_clk); while (lk_busy !== 1'b0);
    lk_req_valid <= 1'b0;
    lk_req.idx <= ~idx;
    n = 0;
    while (lk_rsp_valid !== 1'b1 && n < 40)
    begin
      @(posedge lnk_clk);
      n++;
    end
    d = lk_rsp_data;
    ok = (n < 40);
  endtask
endmodule

// >>> tb_telemetry_fault_log.sv
`timescale 1ns/1ps
module tb_telemetry_fault_log;
  localparam logic [31:0] PREFACE = 32'h4142_4344; // Arbitrary
  logic               mclk, lnk_clk, arst_n, mon_valid, clear_peaks;
  logic               mem_fault, lk_req_valid, lk_busy, lk_rsp_valid;
  logic               nv_wr_req, nv_wr_ack, nv_rd_req, nv_rd_valid;
  logic               nv_erase, valid_log, log_present, logging_en;
  logic               need_erase, copy_hot, ext_fault, erased;
  taf_pkg::taf_rec_t  mon_rec;
  taf_pkg::taf_lreq_t lk_req;
  logic [3:0]         mon_input, cause0, cause1, fault_input;
  logic [15:0]        ext_temp0, ext_temp1, int_temp;
  logic signed [9:0]  die_temp_c;
  logic [47:0]        timestamp;
  logic [1:0]         fault_off, fault_pin_n;
  logic [7:0]         lk_rsp_data, nv_wr_addr, nv_wr_data, nv_rd_addr;
  logic [7:0]         nv_rd_data, d;
  logic [7:0]         nv_mem [0:106];
  logic [7:0]         exp_img [0:146];
  logic [15:0]        pk [0:4];
  taf_pkg::taf_rec_t  hist [$];
  int                 miscompares, checked, cycles;
  bit                 ok;

  taf_fault_log #(.PREFACE(PREFACE)) i_dut (
    .mclk, .arst_n, .lnk_clk, .mon_valid, .mon_rec, .mon_input, .ext_temp0,
    .ext_temp1, .int_temp, .die_temp_c, .timestamp, .clear_peaks, .fault_off,
    .cause0, .cause1, .fault_pin_n, .mem_fault, .lk_req_valid, .lk_req,
    .lk_busy, .lk_rsp_valid, .lk_rsp_data, .nv_wr_req, .nv_wr_addr,
    .nv_wr_data, .nv_wr_ack, .nv_rd_req, .nv_rd_addr, .nv_rd_data,
    .nv_rd_valid, .nv_erase, .valid_log, .log_present, .logging_en,
    .need_erase, .copy_hot, .fault_input, .ext_fault
  );
  taf_host_model i_host (
    .lnk_clk, .lk_busy, .lk_rsp_valid, .lk_rsp_data, .lk_req_valid, .lk_req
  );

  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial
  begin
    lnk_clk = 1'b0;
    #1.3;
    forever #3 lnk_clk = ~lnk_clk;
  end

  // Memory with random write latency; released read data toggles
  always @(posedge mclk)
  begin
    nv_wr_ack <= nv_wr_req && !nv_wr_ack && ($urandom_range(1) == 1);
    if (nv_wr_req && nv_wr_ack)
      nv_mem[nv_wr_addr] <= nv_wr_data;
    nv_rd_valid <= nv_rd_req && !nv_rd_valid;
    nv_rd_data <= (nv_rd_req && !nv_rd_valid) ? nv_mem[nv_rd_addr] : ~nv_rd_data;
    if (nv_erase)
      {erased, nv_mem[0]} <= 9'h100;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      stop_test();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic rd(input taf_pkg::taf_cmd_t op, input int idx);
    i_host.xfer(op, 8'(idx), d, ok);
    check(8'(ok), 8'h01);
  endtask

  task automatic wait_for(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 3000)
    begin
      @(posedge mclk);
      n++;
    end
    check(8'(s === v), 8'h01);
  endtask

  task automatic one_pass;
    taf_pkg::taf_rec_t r;
    r = {$urandom, $urandom, $urandom, $urandom, $urandom};
    @(posedge mclk);
    {mon_valid, mon_rec} <= {1'b1, r};
    {ext_temp0, ext_temp1, int_temp} <= 48'({$urandom, $urandom});
    @(posedge mclk);
    mon_valid <= 1'b0;
    hist.push_front(r);
    foreach (pk[k])
      if (r[159-16*k -: 16] > pk[k])
        pk[k] = r[159-16*k -: 16];
  endtask

  function automatic void build_img(input logic [7:0] src);
    logic [159:0] r;
    logic [79:0]  pw;
    pw = {pk[0], pk[1], pk[2], pk[3], pk[4]};
    for (int k = 0; k < 4; k++)
      exp_img[k] = PREFACE[31-8*k -: 8];
    exp_img[4] = src;
    for (int k = 0; k < 6; k++)
    begin
      exp_img[5+k] = timestamp[8*k +: 8];
      exp_img[21+k] = 8'({ext_temp0, ext_temp1, int_temp} >> (40 - 8*k));
    end
    for (int k = 0; k < 10; k++)
      exp_img[11+k] = pw[79-8*k -: 8];
    for (int j = 0; j < 6; j++)
    begin
      r = hist[j];
      for (int k = 0; k < 20; k++)
        exp_img[27+20*j+k] = r[159-8*k -: 8];
    end
  endfunction

  task automatic stop_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    void'($urandom(49481));
    {arst_n, mon_valid, clear_peaks, mem_fault, nv_wr_ack, nv_rd_valid} = '0;
    {mon_rec, timestamp, ext_temp0, ext_temp1, int_temp} = '0;
    {mon_input, cause0, cause1, fault_off, fault_pin_n} = 16'h3123;
    {die_temp_c, nv_rd_data, erased, miscompares, checked, cycles} = '0;
    foreach (nv_mem[k])
      nv_mem[k] = 8'h00;
    foreach (pk[k])
      pk[k] = taf_pkg::PEAK_RST;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    wait_for(nv_rd_req, 1'b0);
    rd(taf_pkg::CMD_COUNT, 0);
    check(d, taf_pkg::COUNT_NONE);
    check(8'({valid_log, logging_en}), 8'h01);
    $display("test blank boot done");
    fault_pin_n <= 2'b10;
    repeat (7) one_pass();
    check(8'({ext_fault, log_present}), 8'h02);
    $display("test fault pin done");
    {fault_pin_n, die_temp_c} <= {2'b11, 10'sd131};
    timestamp <= 48'({$urandom, $urandom});
    {mon_input, cause1} <= 8'($urandom);
    fault_off <= 2'b10;
    repeat (3) @(posedge mclk);
    one_pass();
    build_img(taf_pkg::SRC_CH1_BASE | {4'h0, cause1});
    wait_for(log_present, 1'b1);
    check(8'(fault_input), 8'(mon_input));
    rd(taf_pkg::CMD_COUNT, 0);
    check(d, taf_pkg::COUNT_FULL);
    for (int k = 0; k < 148; k++)
    begin
      rd(taf_pkg::CMD_BYTE, k);
      check(d, k < 147 ? exp_img[k] : 8'h00);
    end
    check(8'({copy_hot, nv_wr_req}), 8'h02);
    @(posedge mclk);
    die_temp_c <= 10'sd127;
    repeat (20) @(posedge mclk);
    check(8'(copy_hot), 8'h01);
    die_temp_c <= 10'sd124;
    wait_for(nv_wr_req, 1'b1);
    wait_for(nv_wr_req, 1'b0);
    foreach (nv_mem[k])
      check(nv_mem[k], exp_img[k]);
    check(8'(logging_en), 8'h00);
    one_pass();
    rd(taf_pkg::CMD_BYTE, 27);
    check(d, exp_img[27]);
    $display("test fault log done");
    @(posedge mclk);
    {arst_n, fault_off, mem_fault} <= 4'b0001;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    wait_for(nv_rd_req, 1'b0);
    check(8'({valid_log, logging_en}), 8'h02);
    rd(taf_pkg::CMD_BYTE, 40);
    check(d, exp_img[40]);
    rd(taf_pkg::CMD_BYTE, 107);
    check(d, 8'h00);
    rd(taf_pkg::CMD_ERASE, 0);
    check(8'(erased), 8'h00);
    rd(taf_pkg::CMD_CLEAR, 0);
    check(8'({need_erase, logging_en}), 8'h02);
    rd(taf_pkg::CMD_ERASE, 0);
    check(8'({erased, logging_en, valid_log}), 8'h06);
    $display("test stored log done");
    rd(taf_pkg::CMD_STORE, 0);
    one_pass();
    wait_for(nv_wr_req, 1'b1);
    wait_for(nv_wr_req, 1'b0);
    rd(taf_pkg::CMD_BYTE, 4);
    check(d, taf_pkg::SRC_MANUAL);
    $display("test manual store done");
    rd(taf_pkg::CMD_CLEAR, 0);
    @(posedge mclk);
    fault_off <= 2'b01;
    one_pass();
    wait_for(nv_wr_req, 1'b1);
    wait_for(nv_wr_req, 1'b0);
    rd(taf_pkg::CMD_BYTE, 4);
    check(d, taf_pkg::SRC_CH0_BASE | {4'h0, cause0});
    $display("test channel zero done");
    stop_test();
  end
endmodule
